// file: tcu_pkg.sv
// Package for the sixteen-bit counter unit: register map, field layout,
// reset values, counting kinds and the CPU byte-bus carrier.
// Assumes one system clock and an 8-bit CPU I/O bus with single-cycle strobes.
package tcu_pkg;

    // ========================================================================
    // Register map (byte locations on the 8-bit I/O bus)
    // ========================================================================
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CNT_LO     = 4'h0;
    localparam logic [3:0]  ADDR_CNT_HI     = 4'h1;
    localparam logic [3:0]  ADDR_CAP_LO     = 4'h2;
    localparam logic [3:0]  ADDR_CAP_HI     = 4'h3;
    localparam logic [3:0]  ADDR_CMPA_LO    = 4'h4;
    localparam logic [3:0]  ADDR_CMPA_HI    = 4'h5;
    localparam logic [3:0]  ADDR_CMPB_LO    = 4'h6;
    localparam logic [3:0]  ADDR_CMPB_HI    = 4'h7;
    localparam logic [3:0]  ADDR_CTRL_A     = 4'h8;
    localparam logic [3:0]  ADDR_CTRL_B     = 4'h9;
    localparam logic [3:0]  ADDR_FLAGS      = 4'ha;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int          CTRLA_WGM_LSB   = 0;   // Waveform mode bits 1:0
    localparam int          CTRLB_CS_LSB    = 0;   // Clock source select 2:0
    localparam int          CTRLB_WGM_LSB   = 3;   // Waveform mode bits 3:2
    localparam int          FLAG_OVF_BIT    = 0;

    // ========================================================================
    // Values
    // ========================================================================
    localparam logic [15:0] CNT_RESET       = 16'h0000;
    localparam logic [15:0] CNT_FLOOR       = 16'h0000;
    localparam logic [15:0] CNT_MAX         = 16'hffff;
    localparam logic [15:0] TOP_8BIT        = 16'h00ff;
    localparam logic [15:0] TOP_9BIT        = 16'h01ff;
    localparam logic [15:0] TOP_10BIT       = 16'h03ff;
    localparam logic [15:0] CNT_STEP        = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [2:0]  CS_STOPPED      = 3'h0;
    localparam logic [2:0]  CS_DIV1         = 3'h1;
    localparam logic [2:0]  CS_DIV8         = 3'h2;
    localparam logic [2:0]  CS_DIV64        = 3'h3;
    localparam logic [2:0]  CS_DIV256       = 3'h4;
    localparam logic [2:0]  CS_DIV1024      = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL     = 3'h6;
    localparam int          PRESC_W         = 10;
    localparam logic [9:0]  PRESC_MASK8     = 10'h007;
    localparam logic [9:0]  PRESC_MASK64    = 10'h03f;
    localparam logic [9:0]  PRESC_MASK256   = 10'h0ff;
    localparam logic [9:0]  PRESC_MASK1024  = 10'h3ff;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        TCU_KIND_NORMAL,
        TCU_KIND_CLEAR_ON_TOP,
        TCU_KIND_FAST,
        TCU_KIND_DUAL_SLOPE
    } tcu_kind_t;

    typedef struct packed {
        logic              rd;     // One-cycle read strobe
        logic              wr;     // One-cycle write strobe
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } tcu_bus_req_t;

endpackage

// file: tcu_tick_gen.sv
// Tick source for the counter unit: prescaler and external pin edges.
// Assumes the external pin is asynchronous; it is synchronised here.
`timescale 1ns/1ps

module tcu_tick_gen (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Selection
    input  wire logic [2:0] clock_source_select,
    // External event pin
    input  wire logic       ext_pin,
    // Tick out
    output logic            timer_tick
);

    // ========================================================================
    // Prescaler and pin synchroniser
    // ========================================================================
    logic [tcu_pkg::PRESC_W-1:0] presc;
    logic                        pin_meta;
    logic                        pin_sync;
    logic                        pin_prev;
    logic                        next_tick;

    // Free-running divider; shared by all prescaled sources
    always_ff @(posedge clk) begin
        if (rst) begin
            presc <= '0;
        end else if (ce) begin
            presc <= presc + 1'b1;
        end
    end

    // Two flops before any logic looks at the pin; the chain keeps sampling
    // through reset so the edge detector starts at the pin's own level and
    // no false edge follows reset
    always_ff @(posedge clk) begin
        if (ce) begin
            pin_meta <= ext_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Source choice; zero selects nothing so the counter stands still
    always_comb begin
        case (clock_source_select)
            tcu_pkg::CS_STOPPED:  next_tick = 1'b0;
            tcu_pkg::CS_DIV1:     next_tick = 1'b1;
            tcu_pkg::CS_DIV8:     next_tick = &(presc | ~tcu_pkg::PRESC_MASK8);
            tcu_pkg::CS_DIV64:    next_tick = &(presc | ~tcu_pkg::PRESC_MASK64);
            tcu_pkg::CS_DIV256:   next_tick = &(presc | ~tcu_pkg::PRESC_MASK256);
            tcu_pkg::CS_DIV1024:  next_tick = &(presc | ~tcu_pkg::PRESC_MASK1024);
            tcu_pkg::CS_EXT_FALL: next_tick = pin_prev & ~pin_sync;
            default:              next_tick = pin_sync & ~pin_prev;
        endcase
    end

    // Registered tick, one system clock wide
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_tick <= 1'b0;
        end else if (ce) begin
            timer_tick <= next_tick;
        end
    end

endmodule // tcu_tick_gen

// file: tcu_counter_unit.sv
// Sixteen-bit bidirectional counter unit with byte-wide CPU access through
// a shared high-byte holding register, plus the two compare registers.
// Assumes a CPU on the same clock driving one-cycle read/write strobes.
`timescale 1ns/1ps

// Operation
// - High-byte writes, and counter/capture high-byte reads, go to the shared holding register.
// - Low-byte counter read copies counter upper byte into holding register.
// - Low-byte counter write loads holding byte and data together.
// - Holding register keeps its value across low-byte writes.
// - Three-bit clock source select; zero stops the counter.
// - Each tick clears, increments or decrements per operating mode.
// - CPU may read and write counter whether ticking or stopped.
// - CPU counter write beats and discards a coinciding clear or count.
// - Four-bit waveform mode, split over control registers A and B.
// - Overflow flag set at mode's point; usable as interrupt source.
// - Floor shows counter zero; ceiling shows counter at sequence maximum.
// - Counts step by one in chosen direction; clear forces zero.
// - Compare register reads return both bytes without the holding register.
module tcu_counter_unit (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // CPU byte bus
    input  wire tcu_pkg::tcu_bus_req_t bus_req,
    output logic [7:0]                 bus_rdata,
    // External event pin and captured value from the capture unit
    input  wire logic                  ext_pin,
    input  wire logic [15:0]           input_capture_reg,
    // Counter state
    output logic [15:0]                timer_count_value,
    output logic                       overflow_flag,
    output logic                       count_floor,
    output logic                       count_ceiling,
    output logic                       count_down
);

    // ========================================================================
    // Mode helpers
    // ========================================================================
    function automatic tcu_pkg::tcu_kind_t mode_kind(input logic [3:0] wgm);
        case (wgm)
            4'h0, 4'hd:               mode_kind = tcu_pkg::TCU_KIND_NORMAL;
            4'h4, 4'hc:               mode_kind = tcu_pkg::TCU_KIND_CLEAR_ON_TOP;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_kind = tcu_pkg::TCU_KIND_FAST;
            default:                  mode_kind = tcu_pkg::TCU_KIND_DUAL_SLOPE;
        endcase
    endfunction

    function automatic logic [15:0] mode_top(input logic [3:0] wgm,
                                             input logic [15:0] cmp_a,
                                             input logic [15:0] cap);
        case (wgm)
            4'h1, 4'h5:               mode_top = tcu_pkg::TOP_8BIT;
            4'h2, 4'h6:               mode_top = tcu_pkg::TOP_9BIT;
            4'h3, 4'h7:               mode_top = tcu_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf:   mode_top = cmp_a;
            4'h8, 4'ha, 4'hc, 4'he:   mode_top = cap;
            default:                  mode_top = tcu_pkg::CNT_MAX;
        endcase
    endfunction

    // ========================================================================
    // Registers and decode
    // ========================================================================
    logic [7:0]          hold_byte;
    logic [7:0]          control_reg_a;
    logic [7:0]          control_reg_b;
    logic [15:0]         cmp_a;
    logic [15:0]         cmp_b;
    logic                timer_tick;
    logic [3:0]          waveform_mode_select;
    logic [2:0]          clock_source_select;
    tcu_pkg::tcu_kind_t  kind;
    logic [15:0]         top;
    logic                wr_at;
    logic                cnt_wr;
    logic                cnt_rd;
    logic [15:0]         next_count;
    logic                next_down;
    logic                next_ovf_evt;
    logic [7:0]          next_rdata;

    // Mode bits split across both control registers
    assign waveform_mode_select = {control_reg_b[tcu_pkg::CTRLB_WGM_LSB +: 2],
                                   control_reg_a[tcu_pkg::CTRLA_WGM_LSB +: 2]};
    assign clock_source_select  = control_reg_b[tcu_pkg::CTRLB_CS_LSB +: 3];
    assign kind                 = mode_kind(waveform_mode_select);
    assign top                  = mode_top(waveform_mode_select, cmp_a, input_capture_reg);
    assign wr_at                = bus_req.wr;
    assign cnt_wr = bus_req.wr && (bus_req.addr == tcu_pkg::ADDR_CNT_LO);
    assign cnt_rd = bus_req.rd && (bus_req.addr == tcu_pkg::ADDR_CNT_LO);

    // ========================================================================
    // Tick source
    // ========================================================================
    tcu_tick_gen u_tick (
        .clk                 (clk),
        .rst                 (rst),
        .ce                  (ce),
        .clock_source_select (clock_source_select),
        .ext_pin             (ext_pin),
        .timer_tick          (timer_tick)
    );

    // ========================================================================
    // Counting step
    // ========================================================================
    // Next count, direction and overflow event for one tick
    always_comb begin
        next_count   = timer_count_value;
        next_down    = count_down;
        next_ovf_evt = 1'b0;
        if (cnt_wr) begin
            // CPU write wins; the tick in this cycle is dropped
            next_count = {hold_byte, bus_req.wdata};
        end else if (timer_tick) begin
            case (kind)
                tcu_pkg::TCU_KIND_NORMAL: begin
                    next_count   = timer_count_value + tcu_pkg::CNT_STEP;
                    next_ovf_evt = (timer_count_value == tcu_pkg::CNT_MAX);
                end
                tcu_pkg::TCU_KIND_CLEAR_ON_TOP: begin
                    next_count   = (timer_count_value == top) ? tcu_pkg::CNT_RESET
                                 : timer_count_value + tcu_pkg::CNT_STEP;
                    next_ovf_evt = (timer_count_value == tcu_pkg::CNT_MAX);
                end
                tcu_pkg::TCU_KIND_FAST: begin
                    // A top lowered below the count is passed; the count runs on to CNT_MAX and rolls over
                    next_count   = (timer_count_value == top) ? tcu_pkg::CNT_RESET
                                 : timer_count_value + tcu_pkg::CNT_STEP;
                    next_ovf_evt = (timer_count_value == top);
                end
                default: begin
                    // Dual slope turns at top and at the floor
                    if (!count_down && timer_count_value >= top) begin
                        next_down  = 1'b1;
                        next_count = timer_count_value - tcu_pkg::CNT_STEP;
                    end else if (count_down && timer_count_value == tcu_pkg::CNT_FLOOR) begin
                        next_down    = 1'b0;
                        next_count   = timer_count_value + tcu_pkg::CNT_STEP;
                        next_ovf_evt = 1'b1;
                    end else if (count_down) begin
                        next_count = timer_count_value - tcu_pkg::CNT_STEP;
                    end else begin
                        next_count = timer_count_value + tcu_pkg::CNT_STEP;
                    end
                end
            endcase
        end
    end

    // Counter, direction and the floor/ceiling indications, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_count_value <= tcu_pkg::CNT_RESET;
            count_down        <= 1'b0;
            count_floor       <= 1'b1;
            count_ceiling     <= 1'b0;
        end else if (ce) begin
            timer_count_value <= next_count;
            count_down        <= next_down;
            count_floor       <= (next_count == tcu_pkg::CNT_FLOOR);
            count_ceiling     <= (next_count == top);
        end
    end

    // Overflow flag: write one clears, a same-cycle event still sets it
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (ce) begin
            if (next_ovf_evt) begin
                overflow_flag <= 1'b1;
            end else if (wr_at && bus_req.addr == tcu_pkg::ADDR_FLAGS
                         && bus_req.wdata[tcu_pkg::FLAG_OVF_BIT]) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Holding register and CPU-written registers
    // ========================================================================
    // All high-byte locations share one holder; low writes leave it alone
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_byte <= tcu_pkg::BYTE_ZERO;
        end else if (ce) begin
            if (wr_at && (bus_req.addr == tcu_pkg::ADDR_CNT_HI
                       || bus_req.addr == tcu_pkg::ADDR_CAP_HI
                       || bus_req.addr == tcu_pkg::ADDR_CMPA_HI
                       || bus_req.addr == tcu_pkg::ADDR_CMPB_HI)) begin
                hold_byte <= bus_req.wdata;
            end else if (cnt_rd) begin
                hold_byte <= timer_count_value[15:8];
            end else if (bus_req.rd && bus_req.addr == tcu_pkg::ADDR_CAP_LO) begin
                hold_byte <= input_capture_reg[15:8];
            end
        end
    end

    // Control and compare registers; compare values load on the low byte
    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg_a <= tcu_pkg::BYTE_ZERO;
            control_reg_b <= tcu_pkg::BYTE_ZERO;
            cmp_a         <= tcu_pkg::CNT_RESET;
            cmp_b         <= tcu_pkg::CNT_RESET;
        end else if (ce && wr_at) begin
            case (bus_req.addr)
                tcu_pkg::ADDR_CTRL_A:  control_reg_a <= bus_req.wdata;
                tcu_pkg::ADDR_CTRL_B:  control_reg_b <= bus_req.wdata;
                tcu_pkg::ADDR_CMPA_LO: cmp_a <= {hold_byte, bus_req.wdata};
                tcu_pkg::ADDR_CMPB_LO: cmp_b <= {hold_byte, bus_req.wdata};
                default: ;
            endcase
        end
    end

    // ========================================================================
    // Read path
    // ========================================================================
    // Compare reads bypass the holder entirely; unmapped reads give zero
    always_comb begin
        case (bus_req.addr)
            tcu_pkg::ADDR_CNT_LO:  next_rdata = timer_count_value[7:0];
            tcu_pkg::ADDR_CNT_HI,
            tcu_pkg::ADDR_CAP_HI:  next_rdata = hold_byte;
            tcu_pkg::ADDR_CAP_LO:  next_rdata = input_capture_reg[7:0];
            tcu_pkg::ADDR_CMPA_LO: next_rdata = cmp_a[7:0];
            tcu_pkg::ADDR_CMPA_HI: next_rdata = cmp_a[15:8];
            tcu_pkg::ADDR_CMPB_LO: next_rdata = cmp_b[7:0];
            tcu_pkg::ADDR_CMPB_HI: next_rdata = cmp_b[15:8];
            tcu_pkg::ADDR_CTRL_A:  next_rdata = control_reg_a;
            tcu_pkg::ADDR_CTRL_B:  next_rdata = control_reg_b;
            tcu_pkg::ADDR_FLAGS:   next_rdata = {7'h00, overflow_flag};
            default:               next_rdata = tcu_pkg::BYTE_ZERO;
        endcase
    end

    // Read data is registered, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= tcu_pkg::BYTE_ZERO;
        end else if (ce && bus_req.rd) begin
            bus_rdata <= next_rdata;
        end
    end

endmodule // tcu_counter_unit

// file: tcu_counter_unit_sva.sv
// Checker for the counter unit: byte pairing, counting steps and the flag.
// Assumes it is bound into tcu_counter_unit and sees only its ports.
`timescale 1ns/1ps

// ====================================================================
// Checker
// ====================================================================
module tcu_counter_unit_sva (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    // CPU byte bus
    input wire tcu_pkg::tcu_bus_req_t bus_req,
    input wire logic [7:0]            bus_rdata,
    // Counter state
    input wire logic [15:0]           timer_count_value,
    input wire logic                  overflow_flag,
    input wire logic                  count_floor
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Bus cycles that the unit takes
    sequence s_wr(a);
        ce && bus_req.wr && bus_req.addr == a;
    endsequence
    sequence s_rd(a);
        ce && bus_req.rd && bus_req.addr == a;
    endsequence
    // Stop written, then three quiet cycles so the registered tick drains
    sequence s_stop;
        s_wr(tcu_pkg::ADDR_CTRL_B) ##0 bus_req.wdata[2:0] == tcu_pkg::CS_STOPPED
            ##1 (ce && !bus_req.wr)[*3];
    endsequence

    a_reset_clears: assert property (disable iff (1'b0)
        rst && ce |=> timer_count_value == 16'h0000 && !overflow_flag)
        else $error("reset left counter or flag set");
    a_floor_tracks: assert property (
        count_floor == (timer_count_value == tcu_pkg::CNT_FLOOR))
        else $error("floor indication disagrees with counter");
    a_pair_write: assert property (
        s_wr(tcu_pkg::ADDR_CNT_HI) ##1 s_wr(tcu_pkg::ADDR_CNT_LO)
        |=> timer_count_value == {$past(bus_req.wdata, 2), $past(bus_req.wdata)})
        else $error("paired write did not load counter");
    a_read_pair: assert property (
        s_rd(tcu_pkg::ADDR_CNT_LO) ##1 s_rd(tcu_pkg::ADDR_CNT_HI)
        |=> bus_rdata == $past(timer_count_value[15:8], 2))
        else $error("high byte read not from holder");
    a_cmp_holder: assert property (
        s_rd(tcu_pkg::ADDR_CNT_LO) ##1 s_rd(tcu_pkg::ADDR_CMPA_LO)
        ##1 s_rd(tcu_pkg::ADDR_CMPA_HI) ##1 s_rd(tcu_pkg::ADDR_CNT_HI)
        |=> bus_rdata == $past(timer_count_value[15:8], 4))
        else $error("compare read disturbed holder");
    a_step_one: assert property (
        ce && !bus_req.wr |=> timer_count_value == 16'h0000
        || 16'(timer_count_value - $past(timer_count_value)) inside {16'h0000, 16'h0001, 16'hffff})
        else $error("counter moved by more than one");
    a_stop_holds: assert property (
        s_stop |-> $stable(timer_count_value))
        else $error("counter moved with no source selected");
    a_flag_sticky: assert property (
        overflow_flag && !(ce && bus_req.wr && bus_req.addr == tcu_pkg::ADDR_FLAGS
        && bus_req.wdata[0]) |=> overflow_flag)
        else $error("overflow flag dropped without clear");
endmodule // tcu_counter_unit_sva

bind tcu_counter_unit tcu_counter_unit_sva u_sva (
    .clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .timer_count_value(timer_count_value), .overflow_flag(overflow_flag),
    .count_floor(count_floor));

// file: tcu_cpu_model.sv
// CPU model for the counter unit: one-cycle byte strobes on the I/O bus.
// Assumes a single calling thread, so no interrupt code shares the holder.
`timescale 1ns/1ps

// ====================================================================
// CPU bus model
// ====================================================================
module tcu_cpu_model (
    // Clock
    input  wire logic             clk,
    // Byte bus towards the unit
    output tcu_pkg::tcu_bus_req_t bus_req
);
    // Bus idles until the first call
    initial bus_req = '0;

    // One byte cycle: launched after an edge, taken at the next one
    task automatic xfer(input logic rd, input logic wr, input logic [3:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    endtask

    // High byte into the holder first; one thread only, so nothing can
    // slip between the bytes; the priority test calls it with the counter running
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        xfer(1'b0, 1'b1, 4'(lo + 4'h1), v[15:8]);
        xfer(1'b0, 1'b1, lo, v[7:0]);
    endtask
endmodule // tcu_cpu_model

// file: tb.sv
// Self-checking bench for the counter unit: holder use, counting, flag.
// Assumes the CPU model and the bound checker are compiled alongside.
`timescale 1ns/1ps

// ====================================================================
// Bench top
// ====================================================================
module tb;
    // Design signals
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  ce = 1'b1;
    logic                  ext_pin = 1'b1;
    logic [15:0]           input_capture_reg = 16'h0000;
    tcu_pkg::tcu_bus_req_t bus_req;
    logic [7:0]            bus_rdata;
    logic [15:0]           timer_count_value;
    logic                  overflow_flag, count_floor, count_ceiling, count_down;
    // Scoreboard: each note is {mask, expected byte}
    int                    num_errors = 0;
    int                    n_compared = 0;
    int                    seed = 32'h00f3;
    logic [15:0]           expq[$];
    logic [15:0]           note;
    logic [15:0]           v;
    logic                  rd_seen = 1'b0;

    always #4 clk = ~clk;

    tcu_cpu_model cpu (.clk(clk), .bus_req(bus_req));
    tcu_counter_unit dut (
        .clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .ext_pin(ext_pin), .input_capture_reg(input_capture_reg),
        .timer_count_value(timer_count_value), .overflow_flag(overflow_flag),
        .count_floor(count_floor), .count_ceiling(count_ceiling), .count_down(count_down));

    // Bus helpers; reads leave a note for the monitor
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cpu.xfer(1'b0, 1'b1, a, d);
    endtask
    task automatic rd_exp(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        cpu.xfer(1'b1, 1'b0, a, 8'h00);
        expq.push_back({m, e});
    endtask
    task automatic rd16(input logic [3:0] lo, input logic [15:0] e);
        rd_exp(lo, 8'hff, e[7:0]);
        rd_exp(4'(lo + 4'h1), 8'hff, e[15:8]);
    endtask
    // Direct look at a level output that the read monitor cannot see
    task automatic chk(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            $display("unexpected %s: expected %b, seen %b", nm, e, s);
            num_errors++;
        end
    endtask
    // Idle cycles; the idle strobe adds one extra edge that lets the registered tick drain
    task automatic settle(input int n);
        cpu.xfer(1'b0, 1'b0, 4'h0, 8'h00);
        repeat (n) @(posedge clk);
    endtask
    // Four ticks in a given mode, then stop and read counter and flag
    task automatic run_count(input logic [3:0] mode, input logic [15:0] start,
                             input logic [15:0] e, input logic f);
        wr(tcu_pkg::ADDR_FLAGS, 8'h01);
        wr(tcu_pkg::ADDR_CTRL_A, {6'h00, mode[1:0]});
        cpu.wr16(tcu_pkg::ADDR_CNT_LO, start);
        wr(tcu_pkg::ADDR_CTRL_B, {3'h0, mode[3:2], tcu_pkg::CS_DIV1});
        settle(2);
        wr(tcu_pkg::ADDR_CTRL_B, {3'h0, mode[3:2], tcu_pkg::CS_STOPPED});
        settle(2);
        rd16(tcu_pkg::ADDR_CNT_LO, e);
        rd_exp(tcu_pkg::ADDR_FLAGS, 8'h01, {7'h00, f});
        $display("count test mode %0d done", mode);
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Read data lands one edge after the read; match it with the oldest note
    always @(posedge clk) begin
        if (rd_seen) begin
            note = expq.pop_front();
            n_compared++;
            if ((bus_rdata & note[15:8]) !== note[7:0]) begin
                $display("unexpected bus_rdata: expected %h, seen %h", note[7:0], bus_rdata);
                num_errors++;
            end
        end
        rd_seen <= bus_req.rd && ce && !rst;
    end

    // Hang guard, far beyond the roughly 140 cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd16(tcu_pkg::ADDR_CNT_LO, 16'h0000);
        rd_exp(tcu_pkg::ADDR_FLAGS, 8'h01, 8'h00);
        rd_exp(4'hf, 8'hff, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            cpu.wr16(tcu_pkg::ADDR_CNT_LO, v);
            rd16(tcu_pkg::ADDR_CNT_LO, v);
        end
        $display("round trip test done");
        // One high byte serves several low writes; compare reads skip it
        cpu.wr16(tcu_pkg::ADDR_CMPA_LO, 16'h5a3c);
        wr(tcu_pkg::ADDR_CNT_HI, 8'h7e);
        wr(tcu_pkg::ADDR_CNT_LO, 8'h11);
        wr(tcu_pkg::ADDR_CMPB_LO, 8'h22);
        rd_exp(tcu_pkg::ADDR_CNT_LO, 8'hff, 8'h11);
        rd_exp(tcu_pkg::ADDR_CMPA_LO, 8'hff, 8'h3c);
        rd_exp(tcu_pkg::ADDR_CMPA_HI, 8'hff, 8'h5a);
        rd_exp(tcu_pkg::ADDR_CNT_HI, 8'hff, 8'h7e);
        rd_exp(tcu_pkg::ADDR_CMPB_HI, 8'hff, 8'h7e);
        cpu.wr16(tcu_pkg::ADDR_CNT_LO, 16'hffff);
        settle(1);
        chk("count_ceiling", 1'b1, count_ceiling);
        $display("holder test done");
        run_count(4'h0, 16'hfffe, 16'h0002, 1'b1);
        run_count(4'h0, 16'h1000, 16'h1004, 1'b0);
        run_count(4'h5, 16'h00fe, 16'h0002, 1'b1);
        run_count(4'h4, 16'h5a3b, 16'h0002, 1'b0);
        // A write lands on a live tick, which must be lost
        wr(tcu_pkg::ADDR_CTRL_B, {5'h00, tcu_pkg::CS_DIV1});
        cpu.wr16(tcu_pkg::ADDR_CNT_LO, 16'h4321);
        wr(tcu_pkg::ADDR_CTRL_B, 8'h00);
        settle(2);
        rd16(tcu_pkg::ADDR_CNT_LO, 16'h4323);
        $display("priority test done");
        run_count(4'h1, 16'h00fe, 16'h00fc, 1'b0);
        chk("count_down", 1'b1, count_down);
        chk("count_ceiling", 1'b0, count_ceiling);
        settle(3);
        complete_run();
    end
endmodule // tb
